// ==== rirq_pkg.sv ====
// rirq_pkg: register offsets, field positions, reset values and timing
// constants for the radio interrupt and calibration register bank.
// assumes: a 10-bit register address space with 8-bit registers.
package rirq_pkg;

  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [9:0] OFS_AUX_CLK_DIV = 10'h32e;
  localparam logic [9:0] OFS_GAIN_RATE_DIV = 10'h32f;
  localparam logic [9:0] OFS_IRQ_RADIO = 10'h336;
  localparam logic [9:0] OFS_IRQ_SYSTEM = 10'h337;
  localparam logic [9:0] OFS_CAL_ENABLE = 10'h338;
  localparam logic [9:0] OFS_CAL_STATE = 10'h339;
  localparam logic [9:0] OFS_IF_WORD_READ = 10'h345;
  localparam logic [9:0] OFS_IF_WORD_FORCE = 10'h346;
  localparam logic [9:0] OFS_RC_TRIM_HIGH = 10'h34f;

  // reset values
  localparam logic [3:0] RST_AUX_CLK_DIV = 4'h4;
  localparam logic [7:0] RST_GAIN_RATE_DIV = 8'h28;
  localparam logic [7:0] RST_ZERO = 8'h00;

  // first interrupt source register bits
  localparam int B_WAKE_COUNT = 7;
  localparam int B_LISTEN_SIG = 6;
  localparam int B_CRYPT_DONE = 5;
  localparam int B_TX_END = 4;
  localparam int B_ADDR_MATCH = 3;
  localparam int B_CRC_GOOD = 2;
  localparam int B_SYNC_SEEN = 1;
  localparam int B_PREAMBLE_SEEN = 0;

  // second interrupt source register bits
  localparam int B_SUPPLY_LOW = 7;
  localparam int B_CMD_ACCEPT = 6;
  localparam int B_WAKE_EXPIRED = 4;
  localparam int B_PORT_READY = 1;
  localparam int B_CMD_DONE = 0;
  localparam logic [7:0] SYS_USED_MASK = 8'hd3;

  // calibration enable and state bits
  localparam int B_PLL_CAL = 1;
  localparam int B_IF_CAL = 0;
  localparam int B_PA_RAMP = 2;

  // forced filter word field
  localparam int FORCE_EN_BIT = 0;
  localparam int FORCE_WORD_LSB = 1;
  localparam int FORCE_WORD_MSB = 6;
  localparam int CAL_WORD_W = 6;

  // gain loop reference prescale: reference ticks per divisor step
  localparam int REF_MHZ = 26;
  localparam logic [3:0] GAIN_PRESCALE_LAST = 4'(16 - 1);

endpackage : rirq_pkg

// ==== rirq_regs.sv ====
// rirq_regs: register bank holding the auxiliary clock divider, the gain
// loop rate divider, two sticky interrupt source registers and the filter
// and synthesizer calibration controls and results.
// assumes: the control port delivers one-cycle read and write strobes
// synchronous to CLK_I; event inputs are one-cycle pulses; REF_TICK_I is
// a one-cycle strobe at the 26 MHz reference rate.
`timescale 1ns/1ps

// Function
// - aux clock pin outputs crystal over divisor
// - divisor zero stops driving aux clock
// - in fsk mode, gain tick every sixteen times divisor refs
// - flag when wake counter reaches limit
// - flag when listen signal exceeds threshold
// - flag on crypto done, module loaded
// - packet mode tx end flag
// - packet mode address match flag
// - flag on qualified sync word
// - flag on qualified preamble
// - flag when supply drops below threshold
// - flag when processor accepts command
// - flag when wake timer expires
// - flags for port ready, command done
// - enable bit drives pll calibration
// - enable bit drives filter calibration
// - pll calibration done status read
// - filter done status, gated by enable
// - read-only calibrated filter word
// - force bit selects written filter word
// - read-only rc trim high byte
module rirq_regs #(
  parameter int AUX_DIV_W = 4,
  parameter int GAIN_DIV_W = 8
) (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // register port
  input wire logic [rirq_pkg::ADDR_W-1:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic [rirq_pkg::DATA_W-1:0] REG_WDATA_I,
  input wire logic REG_RD_I,
  output logic [rirq_pkg::DATA_W-1:0] REG_RDATA_O,
  output logic REG_RVALID_O,
  // auxiliary clock pin
  output logic AUX_CLOCK_PIN_O,
  output logic AUX_CLOCK_PIN_OE_O,
  // gain loop
  input wire logic REF_TICK_I,
  input wire logic FSK_MODE_I,
  output logic GAIN_LOOP_TICK_O,
  // radio events
  input wire logic PACKET_MODE_I,
  input wire logic [15:0] WAKE_COUNTER_I,
  input wire logic [15:0] WAKE_COUNT_LIMIT_I,
  input wire logic LOW_POWER_LISTEN_I,
  input wire logic LISTEN_RSSI_VALID_I,
  input wire logic [7:0] LISTEN_RSSI_I,
  input wire logic [7:0] LISTEN_SIGNAL_THRESHOLD_I,
  input wire logic CRYPT_LOADED_I,
  input wire logic CRYPT_DONE_I,
  input wire logic TX_END_I,
  input wire logic ADDR_MATCH_I,
  input wire logic CRC_GOOD_I,
  input wire logic SYNC_SEEN_I,
  input wire logic PREAMBLE_SEEN_I,
  // system events
  input wire logic SUPPLY_LOW_I,
  input wire logic CMD_ACCEPT_I,
  input wire logic WAKE_TIMER_EXPIRED_I,
  input wire logic PORT_READY_I,
  input wire logic CMD_DONE_I,
  // calibration
  output logic PLL_CAL_ENABLE_O,
  output logic IF_FILTER_CAL_ENABLE_O,
  input wire logic PLL_CAL_DONE_I,
  input wire logic IF_FILTER_CAL_DONE_I,
  input wire logic PA_RAMP_DONE_I,
  input wire logic [5:0] IF_FILTER_CAL_WORD_I,
  output logic [5:0] IF_FILTER_WORD_O,
  input wire logic [15:0] RC_OSC_TRIM_RESULT_I
);

  localparam int CW = rirq_pkg::CAL_WORD_W;

  // register storage
  logic [AUX_DIV_W-1:0] aux_div_q;
  logic [GAIN_DIV_W-1:0] gain_div_q;
  logic [7:0] irq_radio_q;
  logic [7:0] irq_system_q;
  logic pll_cal_en_q;
  logic if_cal_en_q;
  logic force_en_q;
  logic [CW-1:0] force_word_q;
  logic [CW-1:0] cal_word_q;
  logic [7:0] rc_trim_high_q;

  // event edge history
  logic wake_hit_q;
  logic listen_hit_q;
  logic supply_low_q;
  logic if_done_q;

  // decoded write strobes
  logic wr_aux;
  logic wr_gain;
  logic wr_radio;
  logic wr_system;
  logic wr_cal;
  logic wr_force;

  assign wr_aux = REG_WR_I && (REG_ADDR_I == rirq_pkg::OFS_AUX_CLK_DIV);
  assign wr_gain = REG_WR_I && (REG_ADDR_I == rirq_pkg::OFS_GAIN_RATE_DIV);
  assign wr_radio = REG_WR_I && (REG_ADDR_I == rirq_pkg::OFS_IRQ_RADIO);
  assign wr_system = REG_WR_I && (REG_ADDR_I == rirq_pkg::OFS_IRQ_SYSTEM);
  assign wr_cal = REG_WR_I && (REG_ADDR_I == rirq_pkg::OFS_CAL_ENABLE);
  assign wr_force = REG_WR_I && (REG_ADDR_I == rirq_pkg::OFS_IF_WORD_FORCE);

  // divider registers
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      aux_div_q <= AUX_DIV_W'(rirq_pkg::RST_AUX_CLK_DIV);
      gain_div_q <= GAIN_DIV_W'(rirq_pkg::RST_GAIN_RATE_DIV);
    end else begin
      if (wr_aux) begin
        aux_div_q <= REG_WDATA_I[AUX_DIV_W-1:0];
      end
      if (wr_gain) begin
        gain_div_q <= REG_WDATA_I[GAIN_DIV_W-1:0];
      end
    end
  end

  // auxiliary clock: count 0..div-1, high for the first half
  logic [AUX_DIV_W-1:0] aux_cnt_q;
  logic [AUX_DIV_W-1:0] aux_half;
  logic [AUX_DIV_W:0] aux_sum;
  assign aux_sum = {1'b0, aux_div_q} + {{AUX_DIV_W{1'b0}}, 1'b1};
  assign aux_half = aux_sum[AUX_DIV_W:1];

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      aux_cnt_q <= '0;
      AUX_CLOCK_PIN_O <= 1'b0;
      AUX_CLOCK_PIN_OE_O <= 1'b0;
    end else begin
      AUX_CLOCK_PIN_OE_O <= (aux_div_q != '0);
      if (aux_div_q == '0) begin
        aux_cnt_q <= '0;
        AUX_CLOCK_PIN_O <= 1'b0;
      end else begin
        if (aux_cnt_q >= aux_div_q - AUX_DIV_W'(1)) begin
          aux_cnt_q <= '0;
        end else begin
          aux_cnt_q <= aux_cnt_q + AUX_DIV_W'(1);
        end
        AUX_CLOCK_PIN_O <= (aux_cnt_q < aux_half);
      end
    end
  end

  // gain loop tick: sixteen reference ticks per divisor step
  logic [3:0] pre_cnt_q;
  logic [GAIN_DIV_W-1:0] gain_cnt_q;
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pre_cnt_q <= '0;
      gain_cnt_q <= '0;
      GAIN_LOOP_TICK_O <= 1'b0;
    end else begin
      GAIN_LOOP_TICK_O <= 1'b0;
      if (!FSK_MODE_I || gain_div_q == '0) begin
        pre_cnt_q <= '0; // idle outside frequency-shift modes
        gain_cnt_q <= '0;
      end else if (REF_TICK_I) begin
        if (pre_cnt_q == rirq_pkg::GAIN_PRESCALE_LAST) begin
          pre_cnt_q <= '0;
          if (gain_cnt_q >= gain_div_q - GAIN_DIV_W'(1)) begin
            gain_cnt_q <= '0;
            GAIN_LOOP_TICK_O <= 1'b1;
          end else begin
            gain_cnt_q <= gain_cnt_q + GAIN_DIV_W'(1);
          end
        end else begin
          pre_cnt_q <= pre_cnt_q + 4'h1;
        end
      end
    end
  end

  // level-to-event conversion for conditions that persist
  logic wake_hit;
  logic listen_hit;
  assign wake_hit = (WAKE_COUNTER_I == WAKE_COUNT_LIMIT_I);
  assign listen_hit = LOW_POWER_LISTEN_I && LISTEN_RSSI_VALID_I &&
                      (LISTEN_RSSI_I > LISTEN_SIGNAL_THRESHOLD_I);

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      wake_hit_q <= 1'b0;
      listen_hit_q <= 1'b0;
      supply_low_q <= 1'b0;
      if_done_q <= 1'b0;
    end else begin
      wake_hit_q <= wake_hit;
      listen_hit_q <= listen_hit;
      supply_low_q <= SUPPLY_LOW_I;
      if_done_q <= IF_FILTER_CAL_DONE_I && if_cal_en_q;
    end
  end

  // radio event set vector
  logic [7:0] radio_set;
  always_comb begin
    radio_set = '0;
    radio_set[rirq_pkg::B_WAKE_COUNT] = wake_hit && !wake_hit_q;
    radio_set[rirq_pkg::B_LISTEN_SIG] = listen_hit && !listen_hit_q;
    radio_set[rirq_pkg::B_CRYPT_DONE] = CRYPT_DONE_I && CRYPT_LOADED_I;
    radio_set[rirq_pkg::B_TX_END] = TX_END_I && PACKET_MODE_I;
    radio_set[rirq_pkg::B_ADDR_MATCH] = ADDR_MATCH_I && PACKET_MODE_I;
    radio_set[rirq_pkg::B_CRC_GOOD] = CRC_GOOD_I && PACKET_MODE_I;
    radio_set[rirq_pkg::B_SYNC_SEEN] = SYNC_SEEN_I;
    radio_set[rirq_pkg::B_PREAMBLE_SEEN] = PREAMBLE_SEEN_I;
  end

  // system event set vector
  logic [7:0] system_set;
  always_comb begin
    system_set = '0;
    system_set[rirq_pkg::B_SUPPLY_LOW] = SUPPLY_LOW_I && !supply_low_q;
    system_set[rirq_pkg::B_CMD_ACCEPT] = CMD_ACCEPT_I;
    system_set[rirq_pkg::B_WAKE_EXPIRED] = WAKE_TIMER_EXPIRED_I;
    system_set[rirq_pkg::B_PORT_READY] = PORT_READY_I;
    system_set[rirq_pkg::B_CMD_DONE] = CMD_DONE_I;
  end

  // sticky flags: writing one clears, a same-cycle event wins
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      irq_radio_q <= rirq_pkg::RST_ZERO;
    end else begin
      irq_radio_q <= (irq_radio_q & ~(wr_radio ? REG_WDATA_I : 8'h00))
                     | radio_set;
    end
  end

  // unused bits of the system register never set
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      irq_system_q <= rirq_pkg::RST_ZERO;
    end else begin
      irq_system_q <= ((irq_system_q & ~(wr_system ? REG_WDATA_I : 8'h00))
                       | system_set) & rirq_pkg::SYS_USED_MASK;
    end
  end

  // calibration enables
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pll_cal_en_q <= 1'b0;
      if_cal_en_q <= 1'b0;
    end else if (wr_cal) begin
      pll_cal_en_q <= REG_WDATA_I[rirq_pkg::B_PLL_CAL];
      if_cal_en_q <= REG_WDATA_I[rirq_pkg::B_IF_CAL];
    end
  end

  assign PLL_CAL_ENABLE_O = pll_cal_en_q;
  assign IF_FILTER_CAL_ENABLE_O = if_cal_en_q;

  // forced filter word register
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      force_en_q <= 1'b0;
      force_word_q <= '0;
    end else if (wr_force) begin
      force_en_q <= REG_WDATA_I[rirq_pkg::FORCE_EN_BIT];
      force_word_q <=
        REG_WDATA_I[rirq_pkg::FORCE_WORD_MSB:rirq_pkg::FORCE_WORD_LSB];
    end
  end

  // capture calibrated word when a filter calibration completes
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cal_word_q <= '0;
    end else if (IF_FILTER_CAL_DONE_I && if_cal_en_q && !if_done_q) begin
      cal_word_q <= IF_FILTER_CAL_WORD_I;
    end
  end

  // word applied to the filter oscillator
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      IF_FILTER_WORD_O <= '0;
    end else begin
      IF_FILTER_WORD_O <= force_en_q ? force_word_q : cal_word_q;
    end
  end

  // rc oscillator trim high byte
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rc_trim_high_q <= rirq_pkg::RST_ZERO;
    end else begin
      rc_trim_high_q <= RC_OSC_TRIM_RESULT_I[15:8];
    end
  end

  // read multiplexer
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    case (REG_ADDR_I)
      rirq_pkg::OFS_AUX_CLK_DIV: rd_mux = 8'(aux_div_q);
      rirq_pkg::OFS_GAIN_RATE_DIV: rd_mux = 8'(gain_div_q);
      rirq_pkg::OFS_IRQ_RADIO: rd_mux = irq_radio_q;
      rirq_pkg::OFS_IRQ_SYSTEM: rd_mux = irq_system_q;
      rirq_pkg::OFS_CAL_ENABLE: begin
        rd_mux[rirq_pkg::B_PLL_CAL] = pll_cal_en_q;
        rd_mux[rirq_pkg::B_IF_CAL] = if_cal_en_q;
      end
      rirq_pkg::OFS_CAL_STATE: begin
        rd_mux[rirq_pkg::B_PA_RAMP] = PA_RAMP_DONE_I;
        rd_mux[rirq_pkg::B_PLL_CAL] = PLL_CAL_DONE_I;
        rd_mux[rirq_pkg::B_IF_CAL] = IF_FILTER_CAL_DONE_I && if_cal_en_q;
      end
      rirq_pkg::OFS_IF_WORD_READ: rd_mux = 8'(cal_word_q);
      rirq_pkg::OFS_IF_WORD_FORCE: begin
        rd_mux[rirq_pkg::FORCE_WORD_MSB:rirq_pkg::FORCE_WORD_LSB] =
          force_word_q;
        rd_mux[rirq_pkg::FORCE_EN_BIT] = force_en_q;
      end
      rirq_pkg::OFS_RC_TRIM_HIGH: rd_mux = rc_trim_high_q;
      default: rd_mux = 8'h00;
    endcase
  end

  // registered read answer, one cycle after the strobe
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      REG_RDATA_O <= '0;
      REG_RVALID_O <= 1'b0;
    end else begin
      REG_RVALID_O <= REG_RD_I;
      if (REG_RD_I) begin
        REG_RDATA_O <= rd_mux;
      end
    end
  end

endmodule : rirq_regs

// ==== rirq_chk.sv ====
// rirq_chk: port checks for the radio interrupt and calibration bank.
// assumes: bound to rirq_regs; register strobes are one-cycle pulses.
`timescale 1ns/1ps
module rirq_chk (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic [9:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_RDATA_O,
  input wire logic AUX_CLOCK_PIN_OE_O,
  input wire logic FSK_MODE_I,
  input wire logic GAIN_LOOP_TICK_O,
  input wire logic PREAMBLE_SEEN_I,
  input wire logic PLL_CAL_ENABLE_O,
  input wire logic IF_FILTER_CAL_ENABLE_O,
  input wire logic [5:0] IF_FILTER_WORD_O,
  input wire logic [15:0] RC_OSC_TRIM_RESULT_I
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  // preamble pulse followed at once by a read of the radio flags
  sequence s_pre_rd;
    PREAMBLE_SEEN_I ##1 (REG_RD_I && REG_ADDR_I == 10'h336);
  endsequence
  property p_pre; s_pre_rd |=> REG_RDATA_O[0]; endproperty
  a_pre: assert property (p_pre) else $error("preamble flag missing");
  property p_aux_off;
    REG_WR_I && REG_ADDR_I == 10'h32e && REG_WDATA_I[3:0] == 4'h0
      |-> ##[1:2] !AUX_CLOCK_PIN_OE_O;
  endproperty
  a_aux_off: assert property (p_aux_off) else $error("aux still driven");
  property p_tick_fsk; GAIN_LOOP_TICK_O |-> $past(FSK_MODE_I); endproperty
  a_tick_fsk: assert property (p_tick_fsk) else $error("tick off fsk");
  property p_tick_gap; GAIN_LOOP_TICK_O |=> !GAIN_LOOP_TICK_O [*8]; endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("ticks too close");
  property p_pll;
    REG_WR_I && REG_ADDR_I == 10'h338
      |=> PLL_CAL_ENABLE_O == $past(REG_WDATA_I[1]);
  endproperty
  a_pll: assert property (p_pll) else $error("pll enable wrong");
  property p_ifc;
    REG_WR_I && REG_ADDR_I == 10'h338
      |=> IF_FILTER_CAL_ENABLE_O == $past(REG_WDATA_I[0]);
  endproperty
  a_ifc: assert property (p_ifc) else $error("filter enable wrong");
  property p_force;
    REG_WR_I && REG_ADDR_I == 10'h346 && REG_WDATA_I[0]
      |-> ##2 IF_FILTER_WORD_O == $past(REG_WDATA_I[6:1], 2);
  endproperty
  a_force: assert property (p_force) else $error("forced word unused");
  property p_trim;
    REG_RD_I && REG_ADDR_I == 10'h34f
      |=> REG_RDATA_O == $past(RC_OSC_TRIM_RESULT_I[15:8], 2);
  endproperty
  a_trim: assert property (p_trim) else $error("trim byte wrong");
endmodule : rirq_chk

// ==== rirq_host.sv ====
// rirq_host: host side of the register port with read and write tasks.
// assumes: tasks are entered just after a rising clock edge.
`timescale 1ns/1ps
module rirq_host (
  input wire logic clk_i,
  input wire logic rvalid_i,
  input wire logic [7:0] rdata_i,
  output logic [9:0] addr_o,
  output logic wr_o,
  output logic [7:0] wdata_o,
  output logic rd_o
);
  // idle port at time zero
  initial begin
    addr_o = 10'h000;
    wr_o = 1'b0;
    wdata_o = 8'h00;
    rd_o = 1'b0;
  end
  // one write strobe; address and data scrambled once released
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
    @(posedge clk_i);
  endtask : wr
  // one read strobe; data taken at the edge that shows valid
  task automatic rd(input logic [9:0] a, output logic [7:0] d,
                    output logic ok);
    d = 8'h00;
    ok = 1'b0;
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge clk_i);
      if (rvalid_i === 1'b1) begin
        d = rdata_i;
        ok = 1'b1;
      end
    end
  endtask : rd
endmodule : rirq_host

// ==== tb_radio_irq_cal_regs.sv ====
// tb_radio_irq_cal_regs: self-checking bench for the register bank.
// assumes: rirq_host drives the register port; events come from here.
`timescale 1ns/1ps
`define CHK(g, e, m) \
  begin \
    comparisons++; \
    if ((g) !== (e)) begin \
      bad_count++; \
      $display("[ERR] %0t %s got %0h exp %0h", $time, m, g, e); \
    end \
  end
module tb_radio_irq_cal_regs;
  logic clk = 1'b0, rst_n = 1'b0, ref_tick = 1'b0, fsk = 1'b0, pkt = 1'b1;
  logic lpl = 1'b1, rs_vld = 1'b0, cr_ld = 1'b1, cr_dn = 1'b0;
  logic tx_end = 1'b0, amatch = 1'b0, crc = 1'b0, sync = 1'b0, pre = 1'b0;
  logic sup = 1'b0, cacc = 1'b0, wexp = 1'b0, prdy = 1'b0, cdone = 1'b0;
  logic pll_dn = 1'b0, if_dn = 1'b0, pa_dn = 1'b0;
  logic [15:0] wcnt = 16'h0000, wlim = 16'h1234, trim = 16'ha5c3;
  logic [7:0] rssi = 8'h7f, thr = 8'h7f, wdata, rdata, d;
  logic [5:0] cal_w = 6'h2b, if_word;
  logic [9:0] addr;
  logic wr, rd, rvalid, aux, aux_oe, tick, pll_en, if_en, ok;
  int bad_count = 0, comparisons = 0;
  int bitof [13] = '{0, 1, 2, 3, 4, 5, 6, 7, 0, 1, 4, 6, 7};

  always #4 clk = ~clk;

  rirq_host u_host (.clk_i(clk), .rvalid_i(rvalid), .rdata_i(rdata),
    .addr_o(addr), .wr_o(wr), .wdata_o(wdata), .rd_o(rd));

  rirq_regs dut (.CLK_I(clk), .RST_N_I(rst_n), .REG_ADDR_I(addr),
    .REG_WR_I(wr), .REG_WDATA_I(wdata), .REG_RD_I(rd), .REG_RDATA_O(rdata),
    .REG_RVALID_O(rvalid), .AUX_CLOCK_PIN_O(aux), .AUX_CLOCK_PIN_OE_O(aux_oe),
    .REF_TICK_I(ref_tick), .FSK_MODE_I(fsk), .GAIN_LOOP_TICK_O(tick),
    .PACKET_MODE_I(pkt), .WAKE_COUNTER_I(wcnt), .WAKE_COUNT_LIMIT_I(wlim),
    .LOW_POWER_LISTEN_I(lpl), .LISTEN_RSSI_VALID_I(rs_vld),
    .LISTEN_RSSI_I(rssi), .LISTEN_SIGNAL_THRESHOLD_I(thr),
    .CRYPT_LOADED_I(cr_ld), .CRYPT_DONE_I(cr_dn), .TX_END_I(tx_end),
    .ADDR_MATCH_I(amatch), .CRC_GOOD_I(crc), .SYNC_SEEN_I(sync),
    .PREAMBLE_SEEN_I(pre), .SUPPLY_LOW_I(sup), .CMD_ACCEPT_I(cacc),
    .WAKE_TIMER_EXPIRED_I(wexp), .PORT_READY_I(prdy), .CMD_DONE_I(cdone),
    .PLL_CAL_ENABLE_O(pll_en), .IF_FILTER_CAL_ENABLE_O(if_en),
    .PLL_CAL_DONE_I(pll_dn), .IF_FILTER_CAL_DONE_I(if_dn),
    .PA_RAMP_DONE_I(pa_dn), .IF_FILTER_CAL_WORD_I(cal_w),
    .IF_FILTER_WORD_O(if_word), .RC_OSC_TRIM_RESULT_I(trim));

  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  // a bounded wait ran out
  task automatic tmo;
    $display("[ERR] %0t wait ran out", $time);
    bad_count++;
    results;
  endtask : tmo
  // read one register and compare
  task automatic rdchk(input logic [9:0] a, input logic [7:0] e);
    u_host.rd(a, d, ok);
    if (ok !== 1'b1) tmo;
    else `CHK(d, e, "read")
  endtask : rdchk
  // one event source, high one cycle then back low
  task automatic pulse(input int n);
    for (int v = 1; v >= 0; v--) begin
      case (n)
        0: pre <= v[0];
        1: sync <= v[0];
        2: crc <= v[0];
        3: amatch <= v[0];
        4: tx_end <= v[0];
        5: cr_dn <= v[0];
        6: rs_vld <= v[0];
        7: wcnt <= v[0] ? 16'h1234 : 16'h0000;
        8: cdone <= v[0];
        9: prdy <= v[0];
        10: wexp <= v[0];
        11: cacc <= v[0];
        default: sup <= v[0];
      endcase
      if (v == 1) @(posedge clk);
    end
  endtask : pulse
  // reset values of every register, the live rc trim byte included, and of an unmapped place
  task automatic t_reset;
    logic [9:0] ra [10] = '{10'h32e, 10'h32f, 10'h336, 10'h337, 10'h338,
      10'h339, 10'h345, 10'h346, 10'h34f, 10'h300};
    logic [7:0] rv [10] = '{8'h04, 8'h28, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'ha5, 8'h00};
    rssi <= 8'h80;
    for (int i = 0; i < 10; i++) rdchk(ra[i], rv[i]);
    $display("reset values done");
  endtask : t_reset
  // each source sets its flag, held until written back with one
  task automatic t_flags;
    logic [9:0] a;
    for (int n = 0; n < 13; n++) begin
      a = n < 8 ? 10'h336 : 10'h337;
      pulse(n);
      rdchk(a, 8'h01 << bitof[n]);
      u_host.wr(a, 8'h01 << bitof[n]);
      rdchk(a, 8'h00);
    end
    // clear and a new preamble in one cycle: the event wins
    pulse(0);
    rdchk(10'h336, 8'h01);
    fork
      pulse(0);
      u_host.wr(10'h336, 8'h01);
    join
    rdchk(10'h336, 8'h01);
    u_host.wr(10'h336, 8'h01);
    rdchk(10'h336, 8'h00);
    // gating levels low: packet, crypto and listen flags stay clear
    pkt <= 1'b0;
    cr_ld <= 1'b0;
    lpl <= 1'b0;
    for (int n = 2; n < 7; n++) begin
      pulse(n);
      rdchk(10'h336, 8'h00);
    end
    pkt <= 1'b1;
    cr_ld <= 1'b1;
    lpl <= 1'b1;
    $display("flags done");
  endtask : t_flags
  // aux pin: three periods counted from a rise; zero stops driving
  task automatic t_aux(input logic [3:0] dv);
    int i, hi;
    hi = 0;
    u_host.wr(10'h32e, {4'h0, dv});
    if (dv == 4'h0) begin
      rdchk(10'h32e, 8'h00);
      `CHK(aux_oe, 1'b0, "aux drive")
      `CHK(aux, 1'b0, "aux level")
    end else begin
      for (i = 0; i < 40 && aux !== 1'b0; i++) @(posedge clk);
      if (i == 40) tmo;
      for (i = 0; i < 40 && aux !== 1'b1; i++) @(posedge clk);
      if (i == 40) tmo;
      for (i = 0; i < 3 * dv; i++) begin
        if (aux === 1'b1) hi++;
        @(posedge clk);
      end
      `CHK(hi, 3 * ((int'(dv) + 1) / 2), "aux high")
      `CHK(aux_oe, 1'b1, "aux drive")
    end
    $display("aux divisor %0d done", dv);
  endtask : t_aux
  // 160 reference strobes at divisor 2 give five ticks in fsk only
  task automatic t_gain(input logic f, input int e);
    int tk;
    tk = 0;
    u_host.wr(10'h32f, 8'h02);
    fsk <= f;
    @(posedge clk);
    for (int i = 0; i < 800; i++) begin
      ref_tick <= (i % 5 == 0);
      @(posedge clk);
      if (tick === 1'b1) tk++;
    end
    fsk <= 1'b0;
    `CHK(tk, e, "gain ticks")
    rdchk(10'h32f, 8'h02);
    $display("gain rate done");
  endtask : t_gain
  // calibration enables, status, captured and forced filter word
  task automatic t_cal;
    pll_dn <= 1'b1;
    if_dn <= 1'b1;
    pa_dn <= 1'b1;
    trim <= 16'h3c00;
    u_host.wr(10'h338, 8'h03);
    `CHK(pll_en, 1'b1, "pll enable")
    `CHK(if_en, 1'b1, "filter enable")
    rdchk(10'h339, 8'h07);
    rdchk(10'h345, 8'h2b);
    rdchk(10'h34f, 8'h3c);
    `CHK(if_word, 6'h2b, "filter word")
    u_host.wr(10'h346, 8'h23);
    rdchk(10'h346, 8'h23);
    `CHK(if_word, 6'h11, "forced word")
    u_host.wr(10'h346, 8'h00);
    rdchk(10'h346, 8'h00);
    `CHK(if_word, 6'h2b, "filter word")
    u_host.wr(10'h338, 8'h02);
    u_host.wr(10'h339, 8'hff);
    pll_dn <= 1'b0;
    rdchk(10'h339, 8'h04);
    $display("calibration done");
  endtask : t_cal

  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset;
    t_flags;
    t_aux(4'h4);
    t_aux(4'h3);
    t_aux(4'h0);
    t_gain(1'b1, 5);
    t_gain(1'b0, 0);
    t_cal;
    results;
  end
endmodule : tb_radio_irq_cal_regs

bind rirq_regs rirq_chk u_chk (.CLK_I, .RST_N_I, .REG_ADDR_I, .REG_WR_I,
  .REG_WDATA_I, .REG_RD_I, .REG_RDATA_O, .AUX_CLOCK_PIN_OE_O, .FSK_MODE_I,
  .GAIN_LOOP_TICK_O, .PREAMBLE_SEEN_I, .PLL_CAL_ENABLE_O,
  .IF_FILTER_CAL_ENABLE_O, .IF_FILTER_WORD_O, .RC_OSC_TRIM_RESULT_I);
